// file: pkg/pll_synth_pkg.sv
// Shared constants, types and helpers for the serial-programmed synthesizer
package pll_synth_pkg;

  // System clock
  localparam int CLOCK_PERIOD_NS = 20;

  // Programming word layout
  localparam int SHIFT_WIDTH = 16;
  localparam int N_WIDTH = 14;
  localparam int BAND_A_BIT = 15;
  localparam int BAND_B_BIT = 14;
  localparam int N_LSB = 0;

  // Reset values of the holding latches and the shift register
  localparam logic [13:0] N_RESET = 14'h0010;
  localparam logic BAND_RESET = 1'b1;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;

  // Shortest coincident pulse on both error outputs
  localparam int MIN_PULSE_NS = 60;
  localparam int MIN_PULSE_CYCLES =
    (MIN_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [1:0] MIN_PULSE_LAST = 2'(MIN_PULSE_CYCLES - 1);

  // Reference divide ratios, indexed by the select pins
  localparam logic [13:0] REF_RATIO_0 = 14'h0010;
  localparam logic [13:0] REF_RATIO_1 = 14'h0200;
  localparam logic [13:0] REF_RATIO_2 = 14'h0400;
  localparam logic [13:0] REF_RATIO_3 = 14'h0800;
  localparam logic [13:0] REF_RATIO_4 = 14'h0E54;
  localparam logic [13:0] REF_RATIO_5 = 14'h1000;
  localparam logic [13:0] REF_RATIO_6 = 14'h1800;
  localparam logic [13:0] REF_RATIO_7 = 14'h2000;

  // Phase detector states, Gray along each lead path
  typedef enum logic [1:0] {
    PD_IDLE = 2'b00,
    PD_REF_LEAD = 2'b01,
    PD_CLEAR = 2'b11,
    PD_FB_LEAD = 2'b10
  } pd_state_t;

  // Asynchronous pin inputs, synchronised together
  typedef struct packed {
    logic ref_osc;
    logic feedback;
    logic sclk;
    logic sdata;
    logic en_level;
    logic en_driven;
    logic [2:0] ref_sel;
  } pin_bundle_t;

  // Programming word as held in the shift register and latches
  typedef struct packed {
    logic band_a;
    logic band_b;
    logic [13:0] n_value;
  } prog_word_t;

  // Reference divide ratio for a select code
  function automatic logic [13:0] ref_ratio(input logic [2:0] sel);
    logic [13:0] r;
    r = REF_RATIO_0;
    unique case (sel)
      3'h0: r = REF_RATIO_0;
      3'h1: r = REF_RATIO_1;
      3'h2: r = REF_RATIO_2;
      3'h3: r = REF_RATIO_3;
      3'h4: r = REF_RATIO_4;
      3'h5: r = REF_RATIO_5;
      3'h6: r = REF_RATIO_6;
      3'h7: r = REF_RATIO_7;
    endcase
    return r;
  endfunction : ref_ratio

  // Low-to-high transition between two samples
  function automatic logic rise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction : rise

endpackage : pll_synth_pkg

// file: verilog/pin_sync.sv
// Two-stage synchroniser for the asynchronous pin bundle
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import pll_synth_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire pin_bundle_t pins_async,
  output var pin_bundle_t pins_sync
);

  pin_bundle_t stage1_reg;

  // First stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      pins_sync <= '0;
    end else begin
      stage1_reg <= pins_async;
      pins_sync <= stage1_reg;
    end
  end

endmodule : pin_sync
`default_nettype wire

// file: verilog/freq_divider.sv
// Event-counting divider emitting one pulse per modulus steps
`timescale 1ns/1ps
`default_nettype none
module freq_divider
  import pll_synth_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic step,
  input wire logic [13:0] modulus,
  output logic pulse_out
);

  logic [13:0] count_reg;
  logic [13:0] last_count;

  // Zero modulus acts as divide by one
  assign last_count = (modulus == 14'h0000) ? 14'h0000 :
                      14'(modulus - 14'h0001);

  // Count input edges, wrap and pulse on the last one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 14'h0000;
      pulse_out <= 1'b0;
    end else if (step) begin
      if (count_reg >= last_count) begin
        count_reg <= 14'h0000;
        pulse_out <= 1'b1;
      end else begin
        count_reg <= 14'(count_reg + 14'h0001);
        pulse_out <= 1'b0;
      end
    end else begin
      pulse_out <= 1'b0;
    end
  end

endmodule : freq_divider
`default_nettype wire

// file: verilog/serial_programmed_pll_synth_core.sv
// Digital core of a serially programmed PLL frequency synthesizer
// Notes on behaviour
// - Reference divided by ratio from select pins
// - Feedback fast or leading pulses feedback error
// - Feedback slow or lagging pulses reference error
// - In lock both errors pulse briefly together
// - Single output: low leading, high lagging, else off
// - Lock indicator high locked, low pulses otherwise
// - Serial clock rise shifts data into register
// - Word holds fourteen-bit N and two switch bits
// - Enable high copies shift register into latches
// - Enable low freezes latches while host shifts
// - Undriven enable reads as high
// - Switch outputs latch from first two word bits
// - Latched one floats switch, zero drives low
// - Buffer output copies the reference signal
// - Feedback input clocks the divide-by-N counter
`timescale 1ns/1ps
`default_nettype none
module serial_programmed_pll_synth_core
  import pll_synth_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ref_osc_in,
  input wire logic feedback_freq_in,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic serial_enable,
  input wire logic serial_enable_driven,
  input wire logic ref_select_bit0,
  input wire logic ref_select_bit1,
  input wire logic ref_select_bit2,
  output logic ref_osc_out,
  output logic ref_buffer_out,
  output logic ref_error_n,
  output logic fb_error_n,
  output logic tristate_detector_out,
  output logic tristate_detector_oe_n,
  output logic lock_indicator,
  output logic band_switch_a_out,
  output logic band_switch_a_oe_n,
  output logic band_switch_b_out,
  output logic band_switch_b_oe_n
);

  pin_bundle_t pins_async;
  pin_bundle_t pins_sync;
  pin_bundle_t pins_prev_reg;
  prog_word_t shift_reg;
  prog_word_t latch_reg;
  logic enable_level;
  logic [1:0] sync_fill_reg;
  logic sync_full;
  logic sclk_rise;
  logic ref_rise;
  logic fb_rise;
  logic ref_compare_freq;
  logic fb_compare_freq;
  logic [13:0] ref_modulus;
  pd_state_t pd_state_reg;
  pd_state_t pd_state_next;
  logic [1:0] pulse_cnt_reg;
  logic pulse_done;
  logic pend_ref_reg;
  logic pend_fb_reg;
  logic ref_hit;
  logic fb_hit;

  // Gather pins for the synchroniser
  assign pins_async.ref_osc = ref_osc_in;
  assign pins_async.feedback = feedback_freq_in;
  assign pins_async.sclk = serial_clock;
  assign pins_async.sdata = serial_data;
  assign pins_async.en_level = serial_enable;
  assign pins_async.en_driven = serial_enable_driven;
  assign pins_async.ref_sel = {ref_select_bit2, ref_select_bit1,
                               ref_select_bit0};

  pin_sync u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pins_async(pins_async),
    .pins_sync(pins_sync)
  );

  // Previous synchronised samples for edge detection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev_reg <= '0;
    end else begin
      pins_prev_reg <= pins_sync;
    end
  end

  // Edge events on the clocked pins
  assign sclk_rise = rise(pins_prev_reg.sclk, pins_sync.sclk);
  assign ref_rise = rise(pins_prev_reg.ref_osc, pins_sync.ref_osc);
  assign fb_rise = rise(pins_prev_reg.feedback, pins_sync.feedback);

  // Synchroniser fill: pin samples are stale for two edges after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_fill_reg <= 2'h0;
    end else begin
      sync_fill_reg <= {sync_fill_reg[0], 1'b1};
    end
  end

  assign sync_full = sync_fill_reg[1];

  // Pull-up: an undriven enable pad reads high; stale samples never load
  assign enable_level = sync_full &&
                        (pins_sync.en_driven ? pins_sync.en_level :
                         1'b1);

  // Serial shift register, first bit ends in the top position
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= SHIFT_RESET;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[SHIFT_WIDTH-2:0], pins_sync.sdata};
    end
  end

  // Holding latches, transparent while enable is high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg.band_a <= BAND_RESET;
      latch_reg.band_b <= BAND_RESET;
      latch_reg.n_value <= N_RESET;
    end else if (enable_level) begin
      latch_reg <= shift_reg;
    end
    // Enable low leaves the latches untouched
  end

  // Open-drain band switches: one floats, zero pulls low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      band_switch_a_out <= 1'b0;
      band_switch_b_out <= 1'b0;
      band_switch_a_oe_n <= 1'b1;
      band_switch_b_oe_n <= 1'b1;
    end else begin
      band_switch_a_out <= 1'b0;
      band_switch_b_out <= 1'b0;
      band_switch_a_oe_n <= latch_reg.band_a;
      band_switch_b_oe_n <= latch_reg.band_b;
    end
  end

  // Reference buffer and oscillator inverter copies
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_buffer_out <= 1'b0;
      ref_osc_out <= 1'b1;
    end else begin
      ref_buffer_out <= pins_sync.ref_osc;
      ref_osc_out <= ~pins_sync.ref_osc;
    end
  end

  // Reference divider ratio from the select pins
  assign ref_modulus = ref_ratio(pins_sync.ref_sel);

  freq_divider u_ref_divider (
    .clock(clock),
    .rst_n(rst_n),
    .step(ref_rise),
    .modulus(ref_modulus),
    .pulse_out(ref_compare_freq)
  );

  // Feedback input edges clock the divide-by-N counter
  freq_divider u_n_divider (
    .clock(clock),
    .rst_n(rst_n),
    .step(fb_rise),
    .modulus(latch_reg.n_value),
    .pulse_out(fb_compare_freq)
  );

  // Edges seen during the clear window are kept, not lost
  assign ref_hit = ref_compare_freq | pend_ref_reg;
  assign fb_hit = fb_compare_freq | pend_fb_reg;
  assign pulse_done = (pd_state_reg == PD_CLEAR) &&
                      (pulse_cnt_reg == MIN_PULSE_LAST);

  // Phase detector next state
  always_comb begin
    pd_state_next = pd_state_reg;
    unique case (pd_state_reg)
      PD_IDLE: begin
        if (ref_compare_freq && fb_compare_freq) begin
          pd_state_next = PD_CLEAR;
        end else if (ref_compare_freq) begin
          pd_state_next = PD_REF_LEAD;
        end else if (fb_compare_freq) begin
          pd_state_next = PD_FB_LEAD;
        end
      end
      PD_REF_LEAD: begin
        if (fb_compare_freq) begin
          pd_state_next = PD_CLEAR;
        end
      end
      PD_FB_LEAD: begin
        if (ref_compare_freq) begin
          pd_state_next = PD_CLEAR;
        end
      end
      PD_CLEAR: begin
        if (pulse_done) begin
          if (ref_hit && fb_hit) begin
            pd_state_next = PD_CLEAR;
          end else if (ref_hit) begin
            pd_state_next = PD_REF_LEAD;
          end else if (fb_hit) begin
            pd_state_next = PD_FB_LEAD;
          end else begin
            pd_state_next = PD_IDLE;
          end
        end
      end
    endcase
  end

  // Phase detector state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pd_state_reg <= PD_IDLE;
    end else begin
      pd_state_reg <= pd_state_next;
    end
  end

  // Minimum pulse counter for the clear window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_reg <= 2'h0;
    end else if (pd_state_reg == PD_CLEAR && !pulse_done) begin
      pulse_cnt_reg <= 2'(pulse_cnt_reg + 2'h1);
    end else begin
      pulse_cnt_reg <= 2'h0;
    end
  end

  // Pending edges during the clear window, consume on pulse_done wins over set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_ref_reg <= 1'b0;
      pend_fb_reg <= 1'b0;
    end else if (pd_state_reg == PD_CLEAR && !pulse_done) begin
      pend_ref_reg <= pend_ref_reg | ref_compare_freq;
      pend_fb_reg <= pend_fb_reg | fb_compare_freq;
    end else begin
      pend_ref_reg <= 1'b0;
      pend_fb_reg <= 1'b0;
    end
  end

  // Double-ended error outputs, active low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_error_n <= 1'b1;
      fb_error_n <= 1'b1;
    end else begin
      ref_error_n <= !(pd_state_reg == PD_REF_LEAD ||
                       pd_state_reg == PD_CLEAR);
      fb_error_n <= !(pd_state_reg == PD_FB_LEAD ||
                      pd_state_reg == PD_CLEAR);
    end
  end

  // Single-ended three-state output and lock indicator
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tristate_detector_out <= 1'b0;
      tristate_detector_oe_n <= 1'b1;
      lock_indicator <= 1'b1;
    end else begin
      unique case (pd_state_reg)
        PD_FB_LEAD: begin
          tristate_detector_out <= 1'b0;
          tristate_detector_oe_n <= 1'b0;
          lock_indicator <= 1'b0;
        end
        PD_REF_LEAD: begin
          tristate_detector_out <= 1'b1;
          tristate_detector_oe_n <= 1'b0;
          lock_indicator <= 1'b0;
        end
        PD_IDLE, PD_CLEAR: begin
          tristate_detector_out <= 1'b0;
          tristate_detector_oe_n <= 1'b1;
          lock_indicator <= 1'b1;
        end
      endcase
    end
  end

endmodule : serial_programmed_pll_synth_core
`default_nettype wire

// file: tb/pll_synth_assertions.sv
// Port-level checks on the synthesizer core
`timescale 1ns/1ps
`default_nettype none
module pll_synth_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_enable,
  input wire logic serial_enable_driven,
  input wire logic ref_osc_in,
  input wire logic ref_osc_out,
  input wire logic ref_buffer_out,
  input wire logic ref_error_n,
  input wire logic fb_error_n,
  input wire logic tristate_detector_out,
  input wire logic tristate_detector_oe_n,
  input wire logic lock_indicator,
  input wire logic band_switch_a_out,
  input wire logic band_switch_a_oe_n,
  input wire logic band_switch_b_out,
  input wire logic band_switch_b_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Effective enable and coincident error pulse
  wire logic en_eff = serial_enable | ~serial_enable_driven;
  wire logic both_low = ~ref_error_n & ~fb_error_n;
  sequence s_clear;
    both_low [*3];
  endsequence
  property p_band_out;
    !band_switch_a_out && !band_switch_b_out;
  endproperty
  property p_fb_lead;
    !fb_error_n && ref_error_n |-> !tristate_detector_oe_n &&
      !tristate_detector_out && !lock_indicator;
  endproperty
  property p_ref_lead;
    !ref_error_n && fb_error_n |-> !tristate_detector_oe_n &&
      tristate_detector_out && !lock_indicator;
  endproperty
  property p_idle;
    ref_error_n && fb_error_n |-> tristate_detector_oe_n && lock_indicator;
  endproperty
  property p_clear;
    $rose(both_low) |-> s_clear;
  endproperty
  property p_sw_hold;
    $changed({band_switch_a_oe_n, band_switch_b_oe_n}) |-> $past(en_eff, 4);
  endproperty
  property p_ref_buf;
    ref_osc_out == !ref_buffer_out;
  endproperty
  property p_buf_lag;
    $past(rst_n, 4) |-> ref_buffer_out == $past(ref_osc_in, 3);
  endproperty
  property p_reset;
    $rose(rst_n) |-> ref_error_n && fb_error_n && lock_indicator;
  endproperty
  a_band_out: assert property (p_band_out)
    else $error("band output driven high");
  a_fb_lead: assert property (p_fb_lead)
    else $error("feedback lead outputs wrong");
  a_ref_lead: assert property (p_ref_lead)
    else $error("reference lead outputs wrong");
  a_idle: assert property (p_idle)
    else $error("idle outputs wrong");
  a_clear: assert property (p_clear)
    else $error("coincident pulse too short");
  a_sw_hold: assert property (p_sw_hold)
    else $error("band switch moved without enable");
  a_ref_buf: assert property (p_ref_buf)
    else $error("reference outputs disagree");
  a_buf_lag: assert property (p_buf_lag)
    else $error("reference buffer does not follow its input");
  a_reset: assert property (p_reset)
    else $error("outputs wrong after reset");
endmodule : pll_synth_assertions
bind serial_programmed_pll_synth_core pll_synth_assertions
  pll_synth_assertions_inst (.clock, .rst_n, .serial_enable,
  .serial_enable_driven, .ref_osc_in, .ref_osc_out, .ref_buffer_out,
  .ref_error_n,
  .fb_error_n, .tristate_detector_out, .tristate_detector_oe_n,
  .lock_indicator, .band_switch_a_out, .band_switch_a_oe_n,
  .band_switch_b_out, .band_switch_b_oe_n);
`default_nettype wire

// file: tb/prog_host.sv
// Behavioural host driving the three-wire programming link
`timescale 1ns/1ps
`default_nettype none
module prog_host (
  input wire logic clock,
  output logic serial_clock,
  output logic serial_data,
  output logic serial_enable
);
  // Idle link levels
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b1;
    serial_enable = 1'b0;
  end
  // Wait n edges, then drive after the fixed delay
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step
  // Shift a word MSB first, enable low; d slows the host
  task automatic send(input logic [15:0] w, input int d);
    serial_enable = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      step(1);
      serial_data = w[i];
      step(3 + d);
      serial_clock = 1'b1;
      step(3 + d);
      serial_clock = 1'b0;
      serial_data = ~w[i]; // Hold over, stale level inverted
    end
  endtask : send
  // Enable pulse after the last shift edge
  task automatic strobe();
    step(3);
    serial_enable = 1'b1;
    step(4);
    serial_enable = 1'b0;
  endtask : strobe
endmodule : prog_host
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the synthesizer core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pll_synth_pkg::*;
  logic clock, rst_n, serial_enable_driven, r, f, same;
  wire logic ref_osc_in, feedback_freq_in;
  wire logic serial_clock, serial_data, serial_enable;
  logic ref_select_bit0, ref_select_bit1, ref_select_bit2;
  logic ref_osc_out, ref_buffer_out, ref_error_n, fb_error_n;
  logic tristate_detector_out, tristate_detector_oe_n, lock_indicator;
  logic band_switch_a_out, band_switch_a_oe_n;
  logic band_switch_b_out, band_switch_b_oe_n;
  int rp = 4, fp = 4, fails = 0, checked = 0, n, fo, ro, bo;
  int nf, lo, dn, dp;
  logic [2:0] codes [3] = '{3'h0, 3'h1, 3'h4};
  logic [13:0] rt [3] = '{14'h0010, 14'h0200, 14'h0E54};
  assign ref_osc_in = r;
  assign feedback_freq_in = same ? r : f;
  serial_programmed_pll_synth_core serial_programmed_pll_synth_core_inst (.*);
  prog_host prog_host_inst (.*);
  // Clock and pin waveforms
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    r = 1'b0;
    forever begin
      repeat (rp / 2) @(posedge clock);
      #2 r = ~r;
    end
  end
  initial begin
    f = 1'b0;
    forever begin
      repeat (fp / 2) @(posedge clock);
      #2 f = ~f;
    end
  end
  task automatic tick();
    @(posedge clock);
    #2;
  endtask : tick
  task automatic chk(input string s, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %b got %b", s, e, g);
    end
  endtask : chk
  task automatic chkn(input string s, input int e, input int g);
    checked++;
    if (g != e) begin
      fails++;
      $display("BAD %s exp %0d got %0d", s, e, g);
    end
  endtask : chkn
  // Cycles between the last two falls of each error output
  task automatic gap();
    int k, cr, cf, tr, tf;
    logic pr, pf;
    cr = 0;
    cf = 0;
    tr = 0;
    tf = 0;
    n = 0;
    nf = 0;
    pr = ref_error_n;
    pf = fb_error_n;
    for (k = 0; k < 50000 && (cr < 3 || cf < 3); k++) begin
      tick();
      if (pr === 1'b1 && ref_error_n === 1'b0) begin
        n = k - tr;
        tr = k;
        cr++;
      end
      if (pf === 1'b1 && fb_error_n === 1'b0) begin
        nf = k - tf;
        tf = k;
        cf++;
      end
      pr = ref_error_n;
      pf = fb_error_n;
    end
  endtask : gap
  // Count cycles of one-sided and coincident error pulses
  task automatic watch(input int c);
    fo = 0;
    ro = 0;
    bo = 0;
    lo = 0;
    dn = 0;
    dp = 0;
    repeat (c) begin
      tick();
      lo += int'(lock_indicator === 1'b0);
      dn += int'(tristate_detector_oe_n === 1'b0 &&
        tristate_detector_out === 1'b0);
      dp += int'(tristate_detector_oe_n === 1'b0 &&
        tristate_detector_out === 1'b1);
      fo += int'(fb_error_n === 1'b0 && ref_error_n === 1'b1);
      ro += int'(ref_error_n === 1'b0 && fb_error_n === 1'b1);
      bo += int'(ref_error_n === 1'b0 && fb_error_n === 1'b0);
    end
  endtask : watch
  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Watchdog
  initial begin
    repeat (90000) @(posedge clock);
    fails++;
    tally_and_finish();
  end
  // Test sequence
  initial begin
    rst_n = 1'b0;
    same = 1'b1;
    serial_enable_driven = 1'b1;
    {ref_select_bit2, ref_select_bit1, ref_select_bit0} = 3'h0;
    repeat (16) @(posedge clock);
    #2 rst_n = 1'b1;
    tick();
    chk("band_a_oe_n", 1'b1, band_switch_a_oe_n);
    chk("det_oe_n", 1'b1, tristate_detector_oe_n);
    watch(400);
    chkn("one_sided", 0, fo + ro);
    chk("coincident", 1'b1, bo > 0);
    chkn("lock_low", 0, lo);
    chkn("det_driven", 0, dn + dp);
    $display("test in_phase done");
    prog_host_inst.send(16'h4010, 0);
    repeat (6) tick();
    chk("band_a_held", 1'b1, band_switch_a_oe_n);
    prog_host_inst.strobe();
    repeat (4) tick();
    chk("band_a_oe_n", 1'b0, band_switch_a_oe_n);
    chk("band_b_oe_n", 1'b1, band_switch_b_oe_n);
    chk("band_a_out", 1'b0, band_switch_a_out);
    $display("test latch done");
    prog_host_inst.send(16'h8010, 2);
    serial_enable_driven = 1'b0;
    repeat (8) @(posedge clock);
    #2 serial_enable_driven = 1'b1;
    chk("undriven_a", 1'b1, band_switch_a_oe_n);
    chk("undriven_b", 1'b0, band_switch_b_oe_n);
    $display("test pull_up done");
    same = 1'b0;
    rp = 8;
    for (int k = 0; k < 2; k++) begin
      fp = k ? 12 : 6;
      watch(500);
      watch(1500);
      chkn("wrong_side", 0, k ? fo : ro);
      chk("lead_seen", 1'b1, (k ? ro : fo) > 0);
      chkn("det_wrong", 0, k ? dn : dp);
      chk("det_seen", 1'b1, (k ? dp : dn) > 0);
      chk("lock_pulse", 1'b1, lo > 0);
    end
    $display("test lead_lag done");
    same = 1'b1;
    rp = 4;
    for (int i = 0; i < 3; i++) begin
      {ref_select_bit2, ref_select_bit1, ref_select_bit0} = codes[i];
      prog_host_inst.send({2'b11, rt[i]}, 0);
      prog_host_inst.strobe();
      gap();
      chkn("ref_period", 4 * int'(rt[i]), n);
      chkn("fb_period", 4 * int'(rt[i]), nf);
    end
    $display("test ratios done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
